/* File: motor_sysctl_defines.svh */
// Register indices, field positions, reset values and vector addresses.
`ifndef MOTOR_SYSCTL_DEFINES_SVH
`define MOTOR_SYSCTL_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_PIO_DIRECTION       14'h2004
`define IDX_PIO_LINE_DATA       14'h2005
`define IDX_PIO_IRQ_ENABLE      14'h2006
`define IDX_PIO_IRQ_STATUS      14'h2007
`define IDX_MODE_CONTROL        14'h2015
`define IDX_SYSTEM_STATUS       14'h2016
`define IDX_PERIPH_IRQ_STATUS   14'h2017
`define IDX_PERIPH_IRQ_ENABLE   14'h2019
`define IDX_SS_CONTROL          14'h201a
`define IDX_PIO_FUNCTION_SELECT 14'h2049

// Reset values.
`define RST_PIO_DIRECTION       9'h000
`define RST_PIO_LINE_DATA       9'h000
`define RST_PIO_IRQ_ENABLE      9'h000
`define RST_PIO_FUNCTION_SELECT 9'h1ff
`define RST_MODE_CONTROL        16'h0000
`define RST_PERIPH_IRQ_ENABLE   2'h0
`define RST_SS_CONTROL          2'h0

// Field positions.
`define BIT_SERIAL_PORT_ONE_UART         4
`define BIT_SPI_CPHA            12
`define BIT_SPI_CPOL            13
`define BIT_SPI_MODE            14
`define BIT_SERIAL_PORT_ZERO_UART         15
`define BIT_IRQ_TRIP            0
`define BIT_IRQ_SYNC            1
`define BIT_SS_SW_ENABLE        0
`define BIT_SS_SW_LEVEL         1

// Vector table window in program memory and the start of each slot.
`define VEC_TABLE_FIRST         14'h0000
`define VEC_TABLE_LAST          14'h002f
`define VEC_TRIP                14'h002c
`define VEC_SYNC                14'h000c
`define VEC_PIO                 14'h0008
`define VEC_SOFT1               14'h0018
`define VEC_SOFT0               14'h001c
`define VEC_P0_TX               14'h0010
`define VEC_P0_RX               14'h0014
`define VEC_P1_TX               14'h0020
`define VEC_P1_RX               14'h0024
`define VEC_TIMER               14'h0028

`define RESP_OKAY               2'b00
`define RESP_SLVERR             2'b10

`endif

/* File: motor_sysctl_pkg.sv */
// Types shared by the motor peripheral system controller.
package motor_sysctl_pkg;

  typedef struct packed {
    logic [15:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [15:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  // Core-side requests, in descending priority order.
  typedef struct packed {
    logic soft1;
    logic soft0;
    logic p0_tx;
    logic p0_rx;
    logic p1_tx;
    logic p1_rx;
    logic timer;
  } core_req_t;

  // Internal serial port signals facing the pin multiplexer.
  typedef struct packed {
    logic p1_sclk;
    logic p1_flag;
    logic p1_tx_data;
    logic p0_sclk;
    logic p0_tx_data;
    logic p0_tx_fs;
  } sport_int_t;

  typedef struct packed {
    logic shared_clk;
    logic flag_tx;
    logic p0_tx_data;
    logic p0_tx_fs;
    logic p0_sclk;
  } sport_pin_t;

  typedef struct packed {
    logic       rx_data;
    logic       rx_fs;
    logic       cpol;
    logic       cpha;
    logic       spi_mode;
  } sport_ctl_t;

  typedef struct packed {
    axil_rsp_t   bus;
    logic        aw_held;
    logic        w_held;
    logic [13:0] aw_idx;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [15:0] mode_control;
    logic [8:0]  pio_direction;
    logic [8:0]  pio_line_data;
    logic [8:0]  pio_irq_enable;
    logic [8:0]  pio_irq_status;
    logic [8:0]  pio_function_select;
    logic [1:0]  periph_irq_status;
    logic [1:0]  periph_irq_enable;
    logic [1:0]  ss_control;
    logic        sync_prev;
    logic        trip_prev;
    logic [8:0]  pio_prev;
    logic        irq_n;
    logic        vec_valid;
    logic [13:0] vec_addr;
    logic        periph_reset;
    logic [8:0]  pio_out;
    logic [8:0]  pio_oe_n;
    sport_pin_t  pins;
    sport_ctl_t  ctl;
  } state_t;

endpackage : motor_sysctl_pkg

/* File: motor_periph_system_controller.sv */
// System controller: peripheral interrupt flags, vectoring and port muxing.
//
// Functional notes
// - Vector table spans 0x0000 to 0x002F, four words per source.
// - Unmasked requests reach the core one register stage after arrival.
// - Timer, serial port and software requests vector to their own slot.
// - Enabled peripheral events set their bit in the status register.
// - Shared active-low line stays low while any flag is unacknowledged.
// - Simultaneous requests vector to the highest priority source first.
// - Reading peripheral status clears trip and sync bits, acknowledging.
// - Reading pio status clears all its bits and acknowledges the interrupt.
// - Trip and sync interrupts each have an enable before the shared line.
// - Read-only system status shows trip pin, watchdog and pwm timer state.
// - Any hardware, software or watchdog reset restores default settings.
// - Mode control bit 4 selects port one boot mode or uart mode.
// - Boot mode: shared clock pin carries port one clock, flag pin its flag.
// - Uart mode: shared clock pin carries port zero clock, flag pin tx data.
// - Port zero uart mode without spi mode ties internal rx data and rx frame sync together.
// - Mode control bit 14 puts port zero into master-only spi mode.
// - Spi pins: tx data mosi, rx data miso, tx sync ss, clock sck.
// - Slave select asserts automatically around each transferred word.
// - Software may drive slave select as a general line during transfers.
// - Mode control bits 13 and 12 set spi clock polarity and phase.
// - Sync interrupt on rising sync edge; trip interrupt on falling trip.
// - Each enabled pio input sets its status bit on any level change.
//
// Chosen here: the AXI4-Lite register port.
`include "motor_sysctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module motor_periph_system_controller (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire motor_sysctl_pkg::axil_req_t   axil_req,
  output var  motor_sysctl_pkg::axil_rsp_t   axil_rsp,
  input  wire logic                          pwm_sync_pulse,
  input  wire logic                          pwm_trip_input,
  input  wire logic                          watchdog_expired,
  input  wire logic                          pwm_timer_phase,
  input  wire logic                          periph_reset_req,
  input  wire motor_sysctl_pkg::core_req_t   core_req,
  output logic                               shared_periph_irq_line_n,
  output logic                               irq_vector_valid,
  output logic [13:0]                        irq_vector_addr,
  output logic                               periph_reset,
  input  wire logic [8:0]                    programmable_io_line_in,
  output logic [8:0]                         programmable_io_line_out,
  output logic [8:0]                         programmable_io_line_oe_n,
  input  wire motor_sysctl_pkg::sport_int_t  sport_int,
  input  wire logic                          port_zero_rx_data_pin,
  input  wire logic                          port_zero_rx_frame_sync_pin,
  output var  motor_sysctl_pkg::sport_pin_t  sport_pin,
  output var  motor_sysctl_pkg::sport_ctl_t  sport_ctl
);
  import motor_sysctl_pkg::*;

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Merges the two low byte lanes of a write into a 16-bit register image.
  // Upper lanes are ignored because no register is wider than 16 bits.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic is_mapped(input logic [13:0] idx);
    case (idx)
      `IDX_PIO_DIRECTION, `IDX_PIO_LINE_DATA, `IDX_PIO_IRQ_ENABLE,
      `IDX_PIO_IRQ_STATUS, `IDX_MODE_CONTROL, `IDX_SYSTEM_STATUS,
      `IDX_PERIPH_IRQ_STATUS, `IDX_PERIPH_IRQ_ENABLE, `IDX_SS_CONTROL,
      `IDX_PIO_FUNCTION_SELECT: is_mapped = 1'b1;
      default:                  is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Reset image, shared by the bus reset and the peripheral reset.

  function automatic state_t reset_image();
    state_t r;
    r                     = '0;
    r.bus.awready         = 1'b1;
    r.bus.wready          = 1'b1;
    r.bus.arready         = 1'b1;
    r.mode_control        = `RST_MODE_CONTROL;
    r.pio_direction       = `RST_PIO_DIRECTION;
    r.pio_line_data       = `RST_PIO_LINE_DATA;
    r.pio_irq_enable      = `RST_PIO_IRQ_ENABLE;
    r.pio_function_select = `RST_PIO_FUNCTION_SELECT;
    r.periph_irq_enable   = `RST_PERIPH_IRQ_ENABLE;
    r.ss_control          = `RST_SS_CONTROL;
    r.trip_prev           = 1'b1;
    r.irq_n               = 1'b1;
    r.periph_reset        = 1'b1;
    r.pio_oe_n            = 9'h1ff;
    r.pins.p0_tx_fs       = 1'b1;
    return r;
  endfunction : reset_image

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  logic [13:0] ar_idx;
  logic        rd_hit;
  logic [8:0]  pio_live;
  logic [8:0]  pio_armed;
  logic [8:0]  pio_event;
  logic [1:0]  periph_event;
  logic [8:0]  pio_clear;
  logic [1:0]  periph_clear;
  logic [31:0] rd_data;
  logic        wr_go;
  logic [15:0] wimg;
  logic        p1_uart;
  logic        p0_uart;
  logic        spi;
  logic        ss_word;
  logic [9:0]  src_req;
  logic [13:0] src_vec [10];

  always_comb begin
    next_st = st;
    ar_idx  = axil_req.araddr[15:2];
    rd_hit  = axil_req.arvalid && st.bus.arready;
    wr_go   = st.aw_held && st.w_held;

    // Input lines read their pin, output lines read back the driven value.
    pio_live = (programmable_io_line_in & ~st.pio_direction)
             | (st.pio_line_data & st.pio_direction);

    // Edge detection on the synchronous motor-control inputs.
    // The previous samples reset to the idle pin levels, so releasing reset
    // does not look like an edge.
    periph_event[`BIT_IRQ_SYNC] = pwm_sync_pulse && !st.sync_prev
                                && st.periph_irq_enable[`BIT_IRQ_SYNC];
    periph_event[`BIT_IRQ_TRIP] = !pwm_trip_input && st.trip_prev
                                && st.periph_irq_enable[`BIT_IRQ_TRIP];
    pio_armed = st.pio_irq_enable & ~st.pio_direction
              & st.pio_function_select;
    pio_event = (programmable_io_line_in ^ st.pio_prev) & pio_armed;
    next_st.sync_prev = pwm_sync_pulse;
    next_st.trip_prev = pwm_trip_input;
    next_st.pio_prev  = programmable_io_line_in;

    // Read data mux; unmapped indices answer zero with an error response.
    case (ar_idx)
      `IDX_PIO_DIRECTION:       rd_data = {23'h0, st.pio_direction};
      `IDX_PIO_LINE_DATA:       rd_data = {23'h0, pio_live};
      `IDX_PIO_IRQ_ENABLE:      rd_data = {23'h0, st.pio_irq_enable};
      `IDX_PIO_IRQ_STATUS:      rd_data = {23'h0, st.pio_irq_status};
      `IDX_MODE_CONTROL:        rd_data = {16'h0, st.mode_control};
      `IDX_SYSTEM_STATUS:       rd_data = {28'h0, 1'b0, pwm_timer_phase,
                                           watchdog_expired,
                                           pwm_trip_input};
      `IDX_PERIPH_IRQ_STATUS:   rd_data = {30'h0, st.periph_irq_status};
      `IDX_PERIPH_IRQ_ENABLE:   rd_data = {30'h0, st.periph_irq_enable};
      `IDX_SS_CONTROL:          rd_data = {30'h0, st.ss_control};
      `IDX_PIO_FUNCTION_SELECT: rd_data = {23'h0, st.pio_function_select};
      default:                  rd_data = 32'h0000_0000;
    endcase

    // Read-to-clear acknowledges, only on the accepted read of that index.
    periph_clear = (rd_hit && ar_idx == `IDX_PERIPH_IRQ_STATUS)
                 ? 2'h3 : 2'h0;
    pio_clear    = (rd_hit && ar_idx == `IDX_PIO_IRQ_STATUS)
                 ? 9'h1ff : 9'h000;

    // A set arriving with the clear survives it.
    next_st.periph_irq_status = (st.periph_irq_status & ~periph_clear)
                              | periph_event;
    next_st.pio_irq_status    = (st.pio_irq_status & ~pio_clear)
                              | pio_event;

    // Read channel.
    if (rd_hit) begin
      next_st.bus.rvalid  = 1'b1;
      next_st.bus.arready = 1'b0;
      next_st.bus.rdata   = rd_data;
      next_st.bus.rresp   = is_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (st.bus.rvalid && axil_req.rready) begin
      next_st.bus.rvalid  = 1'b0;
      next_st.bus.arready = 1'b1;
    end

    // Write address and data are taken independently, in either order.
    if (axil_req.awvalid && st.bus.awready) begin
      next_st.aw_held     = 1'b1;
      next_st.aw_idx      = axil_req.awaddr[15:2];
      next_st.bus.awready = 1'b0;
    end
    if (axil_req.wvalid && st.bus.wready) begin
      next_st.w_held     = 1'b1;
      next_st.wdata      = axil_req.wdata;
      next_st.wstrb      = axil_req.wstrb;
      next_st.bus.wready = 1'b0;
    end

    wimg = 16'h0000;
    if (wr_go) begin
      next_st.aw_held    = 1'b0;
      next_st.w_held     = 1'b0;
      next_st.bus.bvalid = 1'b1;
      next_st.bus.bresp  = is_mapped(st.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (st.aw_idx)
        `IDX_PIO_DIRECTION: begin
          wimg = merge16({7'h0, st.pio_direction}, st.wdata, st.wstrb);
          next_st.pio_direction = wimg[8:0];
        end
        `IDX_PIO_LINE_DATA: begin
          wimg = merge16({7'h0, st.pio_line_data}, st.wdata, st.wstrb);
          next_st.pio_line_data = wimg[8:0];
        end
        `IDX_PIO_IRQ_ENABLE: begin
          wimg = merge16({7'h0, st.pio_irq_enable}, st.wdata, st.wstrb);
          next_st.pio_irq_enable = wimg[8:0];
        end
        `IDX_MODE_CONTROL: begin
          next_st.mode_control = merge16(st.mode_control, st.wdata,
                                         st.wstrb);
        end
        `IDX_PERIPH_IRQ_ENABLE: begin
          wimg = merge16({14'h0, st.periph_irq_enable}, st.wdata, st.wstrb);
          next_st.periph_irq_enable = wimg[1:0];
        end
        `IDX_SS_CONTROL: begin
          wimg = merge16({14'h0, st.ss_control}, st.wdata, st.wstrb);
          next_st.ss_control = wimg[1:0];
        end
        `IDX_PIO_FUNCTION_SELECT: begin
          wimg = merge16({7'h0, st.pio_function_select}, st.wdata,
                         st.wstrb);
          next_st.pio_function_select = wimg[8:0];
        end
        default: begin
          wimg = 16'h0000;
        end
      endcase
    end else if (st.bus.bvalid && axil_req.bready) begin
      next_st.bus.bvalid  = 1'b0;
      next_st.bus.awready = 1'b1;
      next_st.bus.wready  = 1'b1;
    end

    // The shared line is built from the next flags, so it is registered with them
    // and a new flag reaches the core on the same edge with no extra wait.
    next_st.irq_n = !(|next_st.periph_irq_status
                   || |next_st.pio_irq_status);

    // Priority vectoring; table order is highest first.
    // The loop runs from the lowest source up, so the highest hit is kept.
    src_req = {st.periph_irq_status[`BIT_IRQ_TRIP],
               st.periph_irq_status[`BIT_IRQ_SYNC],
               |st.pio_irq_status,
               core_req.soft1, core_req.soft0,
               core_req.p0_tx, core_req.p0_rx,
               core_req.p1_tx, core_req.p1_rx,
               core_req.timer};
    src_vec[9] = `VEC_TRIP;
    src_vec[8] = `VEC_SYNC;
    src_vec[7] = `VEC_PIO;
    src_vec[6] = `VEC_SOFT1;
    src_vec[5] = `VEC_SOFT0;
    src_vec[4] = `VEC_P0_TX;
    src_vec[3] = `VEC_P0_RX;
    src_vec[2] = `VEC_P1_TX;
    src_vec[1] = `VEC_P1_RX;
    src_vec[0] = `VEC_TIMER;
    next_st.vec_valid = |src_req;
    next_st.vec_addr  = `VEC_TABLE_FIRST;
    for (int i = 0; i < 10; i++) begin
      if (src_req[i]) begin
        next_st.vec_addr = src_vec[i];
      end
    end

    // Pio pad drive; the enable is low while the line is driven.
    // A line given to its alternate function is never driven from here.
    next_st.pio_out  = st.pio_line_data;
    next_st.pio_oe_n = ~(st.pio_direction & st.pio_function_select);

    // Serial port pin multiplexing.
    p1_uart = st.mode_control[`BIT_SERIAL_PORT_ONE_UART];
    p0_uart = st.mode_control[`BIT_SERIAL_PORT_ZERO_UART];
    spi     = st.mode_control[`BIT_SPI_MODE];
    next_st.pins.shared_clk = p1_uart ? sport_int.p0_sclk
                                      : sport_int.p1_sclk;
    next_st.pins.flag_tx    = p1_uart ? sport_int.p1_tx_data
                                      : sport_int.p1_flag;
    next_st.pins.p0_tx_data = sport_int.p0_tx_data;
    // Slave select is low for the whole word framed by the transmit sync.
    ss_word = !sport_int.p0_tx_fs;
    if (spi && st.ss_control[`BIT_SS_SW_ENABLE]) begin
      next_st.pins.p0_tx_fs = st.ss_control[`BIT_SS_SW_LEVEL];
    end else if (spi) begin
      next_st.pins.p0_tx_fs = ss_word;
    end else begin
      next_st.pins.p0_tx_fs = sport_int.p0_tx_fs;
    end
    // Polarity inverts the idle level; phase goes to the port's shifter.
    next_st.pins.p0_sclk = spi ? (sport_int.p0_sclk ^ st.ctl.cpol)
                               : sport_int.p0_sclk;
    next_st.ctl.cpol     = st.mode_control[`BIT_SPI_CPOL];
    next_st.ctl.cpha     = st.mode_control[`BIT_SPI_CPHA];
    next_st.ctl.spi_mode = spi;
    next_st.ctl.rx_data  = port_zero_rx_data_pin;
    // Spi leaves the receive sync unused, so it is held low.
    if (spi) begin
      next_st.ctl.rx_fs = 1'b0;
    end else if (p0_uart) begin
      next_st.ctl.rx_fs = port_zero_rx_data_pin;
    end else begin
      next_st.ctl.rx_fs = port_zero_rx_frame_sync_pin;
    end

    // A software or watchdog reset returns every control register and flag
    // to default but leaves the bus handshake alone, so the read or write
    // in flight still completes.
    next_st.periph_reset = periph_reset_req;
    if (periph_reset_req) begin
      next_st = reset_image();
      next_st.bus          = st.bus;
      next_st.aw_held      = st.aw_held;
      next_st.w_held       = st.w_held;
      next_st.aw_idx       = st.aw_idx;
      next_st.wdata        = st.wdata;
      next_st.wstrb        = st.wstrb;
      next_st.periph_reset = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  // Every register sits in one flop bank, so the bus reset and the software
  // reset share one image and cannot drift apart.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= reset_image();
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, straight from the state register.

  assign axil_rsp                  = st.bus;
  assign shared_periph_irq_line_n  = st.irq_n;
  assign irq_vector_valid          = st.vec_valid;
  assign irq_vector_addr           = st.vec_addr;
  assign periph_reset              = st.periph_reset;
  assign programmable_io_line_out  = st.pio_out;
  assign programmable_io_line_oe_n = st.pio_oe_n;
  assign sport_pin                 = st.pins;
  assign sport_ctl                 = st.ctl;

endmodule : motor_periph_system_controller

`default_nettype wire

/* File: motor_sysctl_sva.sv */
// Checker for the interrupt and serial pin relations at the controller ports.
`timescale 1ns/100ps
`default_nettype none
module motor_sysctl_sva import motor_sysctl_pkg::*; (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire axil_req_t   axil_req,
  input wire axil_rsp_t   axil_rsp,
  input wire logic        pwm_trip_input,
  input wire logic        periph_reset_req,
  input wire core_req_t   core_req,
  input wire logic        shared_periph_irq_line_n,
  input wire logic        irq_vector_valid,
  input wire logic [13:0] irq_vector_addr,
  input wire sport_int_t  sport_int,
  input wire sport_pin_t  sport_pin,
  input wire sport_ctl_t  sport_ctl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Only a status read or a peripheral reset may release the shared line.
  property p_irq_hold;
    !shared_periph_irq_line_n && !(axil_req.arvalid && axil_rsp.arready)
      && !periph_reset_req |=> !shared_periph_irq_line_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("line released");
  property p_trip_vec;
    $fell(pwm_trip_input) && shared_periph_irq_line_n ##[1:2]
      $fell(shared_periph_irq_line_n) |-> ##[1:2] irq_vector_addr == 14'h002c;
  endproperty
  a_trip_vec: assert property (p_trip_vec) else $error("trip vector");
  property p_vec_stage;
    $fell(shared_periph_irq_line_n) |-> ##[0:1] irq_vector_valid;
  endproperty
  a_vec_stage: assert property (p_vec_stage) else $error("vector late");
  // A peripheral reset clears the vector, so that cycle is left out.
  property p_core_prio;
    shared_periph_irq_line_n && !periph_reset_req && core_req.soft1
      |=> irq_vector_addr == 14'h0018;
  endproperty
  a_core_prio: assert property (p_core_prio) else $error("priority");
  property p_core_timer;
    shared_periph_irq_line_n && !periph_reset_req && core_req == 7'h01
      |=> irq_vector_addr == 14'h0028;
  endproperty
  a_core_timer: assert property (p_core_timer) else $error("timer slot");
  // The pins follow the mode that the control stage already shows.
  property p_sck;
    sport_ctl.spi_mode |->
      sport_pin.p0_sclk == ($past(sport_int.p0_sclk) ^ $past(sport_ctl.cpol));
  endproperty
  a_sck: assert property (p_sck) else $error("sck polarity");
  property p_mosi;
    sport_ctl.spi_mode |-> sport_pin.p0_tx_data == $past(sport_int.p0_tx_data);
  endproperty
  a_mosi: assert property (p_mosi) else $error("mosi");
  property p_reset;
    periph_reset_req [*2] |=> shared_periph_irq_line_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset kept line");
endmodule : motor_sysctl_sva
bind motor_periph_system_controller motor_sysctl_sva motor_sysctl_sva_i (.*);
`default_nettype wire

/* File: dsp_core_model.sv */
// Core side: raises its own requests and takes the offered vector.
`timescale 1ns/100ps
`default_nettype none
module dsp_core_model import motor_sysctl_pkg::*; (
  input wire logic        aclk,
  input wire core_req_t   want,
  input wire logic        irq_vector_valid,
  input wire logic [13:0] irq_vector_addr,
  output core_req_t       core_req,
  output logic [13:0]     taken
);
  always_ff @(posedge aclk) begin
    core_req <= want;
    if (irq_vector_valid) taken <= irq_vector_addr;
  end
endmodule : dsp_core_model
`default_nettype wire

/* File: tb_top.sv */
// Register and pin level tests of the system controller.
`include "motor_sysctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import motor_sysctl_pkg::*;
  logic aclk = 0, aresetn = 0, pwm_sync_pulse = 0, pwm_trip_input = 1;
  logic watchdog_expired = 1, pwm_timer_phase = 1, periph_reset_req = 0;
  logic port_zero_rx_data_pin = 1, port_zero_rx_frame_sync_pin = 0;
  logic shared_periph_irq_line_n, irq_vector_valid, periph_reset;
  logic [13:0] irq_vector_addr, taken;
  logic [8:0] programmable_io_line_in = 0, programmable_io_line_out;
  logic [8:0] programmable_io_line_oe_n;
  logic [31:0] d;
  logic [1:0] r;
  int mismatches = 0, checks_done = 0, cycles = 0;
  axil_req_t axil_req = '0;
  axil_rsp_t axil_rsp;
  core_req_t want = '0, core_req;
  sport_int_t sport_int = 6'b110000;
  sport_pin_t sport_pin;
  sport_ctl_t sport_ctl;
  logic [13:0] ri [5] = '{`IDX_PIO_DIRECTION, `IDX_PIO_IRQ_ENABLE,
    `IDX_PIO_FUNCTION_SELECT, `IDX_MODE_CONTROL, `IDX_PERIPH_IRQ_ENABLE};
  logic [31:0] re [5] = '{32'h0, 32'h0, 32'h1ff, 32'h0, 32'h0};
  motor_periph_system_controller motor_periph_system_controller_i (.*);
  dsp_core_model dsp_core_model_i (.*);
  always #5 aclk = ~aclk;
  always @(posedge aclk) if (++cycles == 20000) begin
    mismatches++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [13:0] i, input logic [31:0] v);
    axil_req.awaddr <= {i, 2'b00};
    axil_req.wdata <= v;
    axil_req.awvalid <= 1;
    axil_req.wvalid <= 1;
    fork
      begin do @(negedge aclk); while (axil_rsp.awready !== 1'b1);
        @(posedge aclk); axil_req.awvalid <= 0; end
      begin do @(negedge aclk); while (axil_rsp.wready !== 1'b1);
        @(posedge aclk); axil_req.wvalid <= 0; end
    join
    do @(negedge aclk); while (axil_rsp.bvalid !== 1'b1);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [13:0] i, output logic [31:0] v, output logic [1:0] e);
    axil_req.araddr <= {i, 2'b00};
    axil_req.arvalid <= 1;
    do @(negedge aclk); while (axil_rsp.arready !== 1'b1);
    @(posedge aclk);
    axil_req.arvalid <= 0;
    do @(negedge aclk); while (axil_rsp.rvalid !== 1'b1);
    v = axil_rsp.rdata;
    e = axil_rsp.rresp;
    @(posedge aclk);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  initial begin
    axil_req.wstrb = 4'hf;
    axil_req.bready = 1;
    axil_req.rready = 1;
    cyc(8);
    aresetn <= 1;
    cyc(1);
    foreach (ri[k]) begin rd(ri[k], d, r); chk("reset value", re[k], d); end
    rd(14'h2014, d, r); chk("unmapped resp", `RESP_SLVERR, r);
    rd(`IDX_SYSTEM_STATUS, d, r); chk("system status", 32'h7, d);
    chk("boot clk", 1, sport_pin.shared_clk);
    chk("boot flag", 1, sport_pin.flag_tx);
    wr(`IDX_PERIPH_IRQ_ENABLE, 32'h3);
    pwm_trip_input <= 0; pwm_sync_pulse <= 1; cyc(4);
    chk("irq line", 0, shared_periph_irq_line_n);
    chk("first vector", 14'h002c, taken);
    rd(`IDX_PERIPH_IRQ_STATUS, d, r); chk("periph status", 32'h3, d);
    cyc(2); chk("acknowledged", 1, shared_periph_irq_line_n);
    pwm_trip_input <= 1; wr(`IDX_PERIPH_IRQ_ENABLE, 32'h0);
    pwm_trip_input <= 0; cyc(4);
    chk("masked trip", 1, shared_periph_irq_line_n);
    wr(`IDX_PIO_IRQ_ENABLE, 32'h3); wr(`IDX_PIO_DIRECTION, 32'h2);
    programmable_io_line_in <= 9'h003; cyc(4);
    chk("pio line", 0, shared_periph_irq_line_n);
    rd(`IDX_PIO_IRQ_STATUS, d, r); chk("pio status", 32'h1, d);
    cyc(2); chk("pio acked", 1, shared_periph_irq_line_n);
    rd(`IDX_PIO_IRQ_STATUS, d, r); chk("pio cleared", 32'h0, d);
    wr(`IDX_PIO_LINE_DATA, 32'h2); cyc(2);
    chk("pio out", 32'h2, programmable_io_line_out);
    chk("pio oe_n", 32'h1fd, programmable_io_line_oe_n);
    rd(`IDX_PIO_LINE_DATA, d, r); chk("pio live", 32'h3, d);
    want <= 7'h41; cyc(4); chk("soft1 first", 14'h0018, taken);
    want <= 7'h01; cyc(4); chk("timer slot", 14'h0028, taken);
    want <= 7'h00;
    wr(`IDX_MODE_CONTROL, 32'h8010); cyc(3);
    chk("uart clk", 0, sport_pin.shared_clk);
    chk("uart tx", 0, sport_pin.flag_tx);
    chk("rx tied", 1, sport_ctl.rx_fs);
    sport_int <= 6'b000111; wr(`IDX_MODE_CONTROL, 32'h7000); cyc(3);
    chk("spi mode", 1, sport_ctl.spi_mode);
    chk("sck", 0, sport_pin.p0_sclk);
    chk("ss active", 0, sport_pin.p0_tx_fs);
    chk("cpha", 1, sport_ctl.cpha);
    chk("mosi", 1, sport_pin.p0_tx_data);
    chk("miso", 1, sport_ctl.rx_data);
    chk("rx fs unused", 0, sport_ctl.rx_fs);
    wr(`IDX_SS_CONTROL, 32'h3); cyc(3);
    chk("ss by software", 1, sport_pin.p0_tx_fs);
    chk("mosi kept", 1, sport_pin.p0_tx_data);
    periph_reset_req <= 1; cyc(2);
    chk("periph reset", 1, periph_reset);
    periph_reset_req <= 0; cyc(2);
    chk("periph reset end", 0, periph_reset);
    rd(`IDX_MODE_CONTROL, d, r); chk("mode after reset", 32'h0, d);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
